// [verilog/sync_serial_params.svh]
// Register map, field positions and timing counts of the serial unit
//
// Contract
// - The master select bit picks master (clock driven out) or slave (0).
// - A conflict error clears the master select bit, forcing slave mode.
// - Clock pin select 0 leaves the clock pin a port, 1 makes it serial.
// - Mode select 0 is clocked synchronous mode on the data in/out pins.
// - Bit order select 0 shifts the LSB first, 1 the MSB first.
// - The rate field divides the system clock; code 101 gives phi/8.
// - Transmit enable 1 permits transmission, 0 inhibits it.
// - Receive enable 1 permits reception, 0 inhibits it.
// - A byte completed while receive-full is 1 sets the overrun flag.
// - On overrun the held byte stays and the new byte is dropped.
// - While overrun is set no further reception takes place.
// - While overrun is set in master mode transmission halts too.
// - Overrun, transmit-end and conflict clear by writing 0 after reading 1; receive-full clears on a receive data read.
// - Each received byte moves from the shift register to receive data unless receive-full is 1.
// - Standby bit 0 holds the unit in standby, 1 lets it run.
`ifndef SYNC_SERIAL_PARAMS_SVH
`define SYNC_SERIAL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_CONTROL_HIGH 16'hF0E0
`define ADDR_CONTROL_LOW 16'hF0E1
`define ADDR_MODE_CONFIG 16'hF0E2
`define ADDR_TX_RX_ENABLE 16'hF0E3
`define ADDR_SERIAL_STATUS 16'hF0E4
`define ADDR_RX_DATA 16'hF0E9
`define ADDR_TX_DATA 16'hF0EB
`define ADDR_IRQ_STATUS 16'hF0F0
`define ADDR_IRQ_ENABLE 16'hF0F1
`define ADDR_IRQ_CLEAR 16'hF0F2
`define ADDR_STANDBY 16'hFFFB

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_MASTER 7
`define BIT_CLK_PIN 2
`define BIT_PIN_MODE 6
`define BIT_ORDER 7
`define RATE_MSB 2
`define RATE_LSB 0
`define BIT_TX_EN 7
`define BIT_RX_EN 6
`define BIT_OVERRUN 6
`define BIT_TX_END 3
`define BIT_TX_EMPTY 2
`define BIT_RX_FULL 1
`define BIT_CONFLICT 0
`define BIT_STANDBY 4
`define IRQ_RX_FULL 0
`define IRQ_OVERRUN 1
`define IRQ_TX_END 2
`define IRQ_CONFLICT 3
`define IRQ_W 4

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_IRQ 4'h0
`define LAST_BIT 3'h7
`define FIRST_BIT 3'h0
`define CE_RATE_LIMIT 3'h5
// Half bit period minus one, in system clock cycles, per rate code
`define HALF_M1_0 8'h7F
`define HALF_M1_1 8'h3F
`define HALF_M1_2 8'h1F
`define HALF_M1_3 8'h0F
`define HALF_M1_4 8'h07
`define HALF_M1_5 8'h03
`define HALF_M1_6 8'h01
`define HALF_M1_7 8'h00

`endif

// [verilog/sync_serial_pkg.sv]
// Types shared by the serial unit files
package sync_serial_pkg;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_LOW = 2'b01,
        M_HIGH = 2'b11
    } master_state_type;

endpackage : sync_serial_pkg

// [verilog/rate_divider.sv]
// Prescaler that yields one tick per half transfer-clock period
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_params.svh"

module rate_divider
    import sync_serial_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic run_i,
    input wire logic [2:0] rate_i,
    // Half-period pulse
    output logic tick_o
);

    logic [7:0] count_r;
    logic [7:0] reload;

    always_comb begin
        case (rate_i)
            3'h0: reload = `HALF_M1_0;
            3'h1: reload = `HALF_M1_1;
            3'h2: reload = `HALF_M1_2;
            3'h3: reload = `HALF_M1_3;
            3'h4: reload = `HALF_M1_4;
            3'h5: reload = `HALF_M1_5;
            3'h6: reload = `HALF_M1_6;
            default: reload = `HALF_M1_7;
        endcase
    end

    // Reload while idle so the first half period is always whole
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_r <= 8'h00;
        end else if (!run_i || count_r == 8'h00) begin
            count_r <= reload;
        end else begin
            count_r <= count_r - 8'h01;
        end
    end

    assign tick_o = run_i && (count_r == 8'h00);

endmodule : rate_divider
`default_nettype wire

// [verilog/sync_serial_unit.sv]
// Clocked synchronous serial unit: registers, shift engine and pins
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_params.svh"

module sync_serial_unit
    import sync_serial_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Serial clock pin
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_o,
    // Serial data pins
    input wire logic serial_input_pin_i,
    output logic serial_output_pin_o,
    output logic serial_output_pin_oe_o,
    // Interrupt
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic master_slave_select_r;
    logic clock_pin_select_r;
    logic pin_mode_select_r;
    logic bit_order_select_r;
    logic [2:0] clock_rate_r;
    logic transmit_enable_bit_r;
    logic receive_enable_bit_r;
    logic module_standby_control_r;
    logic overrun_error_flag_r;
    logic receive_data_full_flag_r;
    logic tx_empty_r;
    logic tx_end_r;
    logic conflict_r;
    logic [2:0] seen_r;
    logic [7:0] receive_data_register_r;
    logic [7:0] tx_data_r;
    logic [7:0] shift_register_r;
    logic out_bit_r;
    logic [`IRQ_W-1:0] irq_status_r;
    logic [`IRQ_W-1:0] irq_enable_r;
    logic irq_r;
    logic [7:0] rdata_r;
    logic sck_s1_r, sck_s2_r, sck_s3_r, sck_st_r, sck_prev_r;
    logic si_s1_r, si_s2_r, si_s3_r, si_st_r;
    master_state_type state_r;
    logic [2:0] m_cnt_r;
    logic [2:0] s_cnt_r;
    logic s_done_r;
    logic sck_r;
    logic tick;
    logic master_active, slave_active;
    logic start, m_shift, m_done;
    logic s_sample, s_shift, byte_done, sample;
    logic tx_load, tx_wr, status_wr, status_rd;
    logic rx_store, overrun_set, tx_end_set, conflict_set;
    logic clr_overrun, clr_tx_end, clr_conflict;
    logic [7:0] status_val;
    logic [7:0] read_val, shifted;

    function automatic logic lead_bit(input logic msb_first,
                                      input logic [7:0] b);
        lead_bit = msb_first ? b[7] : b[0];
    endfunction : lead_bit

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    assign tx_wr = reg_wr_i && reg_addr_i == `ADDR_TX_DATA;
    assign status_wr = reg_wr_i && reg_addr_i == `ADDR_SERIAL_STATUS;
    assign status_rd = reg_rd_i && reg_addr_i == `ADDR_SERIAL_STATUS;

    // Conflict clears the master bit even against a same-cycle write
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            master_slave_select_r <= 1'b0;
            clock_pin_select_r <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == `ADDR_CONTROL_HIGH) begin
                master_slave_select_r <= reg_wdata_i[`BIT_MASTER];
                clock_pin_select_r <= reg_wdata_i[`BIT_CLK_PIN];
            end
            if (conflict_set) begin
                master_slave_select_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_mode_select_r <= 1'b0;
            bit_order_select_r <= 1'b0;
            clock_rate_r <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == `ADDR_CONTROL_LOW) begin
            pin_mode_select_r <= reg_wdata_i[`BIT_PIN_MODE];
        end else if (reg_wr_i && reg_addr_i == `ADDR_MODE_CONFIG) begin
            bit_order_select_r <= reg_wdata_i[`BIT_ORDER];
            clock_rate_r <= reg_wdata_i[`RATE_MSB:`RATE_LSB];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            transmit_enable_bit_r <= 1'b0;
            receive_enable_bit_r <= 1'b0;
            module_standby_control_r <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == `ADDR_TX_RX_ENABLE) begin
            transmit_enable_bit_r <= reg_wdata_i[`BIT_TX_EN];
            receive_enable_bit_r <= reg_wdata_i[`BIT_RX_EN];
        end else if (reg_wr_i && reg_addr_i == `ADDR_STANDBY) begin
            module_standby_control_r <= reg_wdata_i[`BIT_STANDBY];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_data_r <= `RST_BYTE;
        end else if (tx_wr) begin
            tx_data_r <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // A level counts only once two later stages agree
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            sck_st_r <= 1'b0;
            sck_prev_r <= 1'b0;
        end else begin
            sck_s1_r <= serial_clock_pin_i;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            if (sck_s2_r == sck_s3_r) begin
                sck_st_r <= sck_s3_r;
            end
            sck_prev_r <= sck_st_r;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            si_s1_r <= 1'b0;
            si_s2_r <= 1'b0;
            si_s3_r <= 1'b0;
            si_st_r <= 1'b0;
        end else begin
            si_s1_r <= serial_input_pin_i;
            si_s2_r <= si_s1_r;
            si_s3_r <= si_s2_r;
            if (si_s2_r == si_s3_r) begin
                si_st_r <= si_s3_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode qualification
    // ------------------------------------------------------------------
    // Mode select 1 covers modes this unit leaves idle
    assign master_active = master_slave_select_r && clock_pin_select_r
        && !pin_mode_select_r && module_standby_control_r;
    assign slave_active = !master_slave_select_r && clock_pin_select_r
        && !pin_mode_select_r && module_standby_control_r
        && (transmit_enable_bit_r || receive_enable_bit_r);

    rate_divider u_rate_divider (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .run_i(master_active && state_r != M_IDLE),
        .rate_i(clock_rate_r),
        .tick_o(tick)
    );

    // ------------------------------------------------------------------
    // Master engine
    // ------------------------------------------------------------------
    assign start = master_active && state_r == M_IDLE && !tx_wr
        && !overrun_error_flag_r
        && ((transmit_enable_bit_r && !tx_empty_r)
            || (receive_enable_bit_r && !transmit_enable_bit_r));
    assign m_shift = state_r == M_HIGH && tick && m_cnt_r != `LAST_BIT;
    assign m_done = state_r == M_HIGH && tick && m_cnt_r == `LAST_BIT;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= M_IDLE;
            m_cnt_r <= `FIRST_BIT;
            sck_r <= 1'b0;
        end else if (!master_active) begin
            state_r <= M_IDLE;
            m_cnt_r <= `FIRST_BIT;
            sck_r <= 1'b0;
        end else begin
            case (state_r)
                M_IDLE: begin
                    if (start) begin
                        state_r <= M_LOW;
                        m_cnt_r <= `FIRST_BIT;
                    end
                end
                M_LOW: begin
                    if (tick) begin
                        state_r <= M_HIGH;
                        sck_r <= 1'b1;
                    end
                end
                M_HIGH: begin
                    if (tick) begin
                        sck_r <= 1'b0;
                        m_cnt_r <= m_cnt_r + 3'h1;
                        state_r <= m_done ? M_IDLE : M_LOW;
                    end
                end
                default: begin
                    state_r <= M_IDLE;
                end
            endcase
        end
    end

    // Fast rates are skipped: the synchronised pin echo lags the driven clock
    assign conflict_set = master_active && tick && state_r != M_IDLE
        && clock_rate_r < `CE_RATE_LIMIT && sck_st_r != sck_r;

    // ------------------------------------------------------------------
    // Slave engine
    // ------------------------------------------------------------------
    assign s_sample = slave_active && sck_st_r && !sck_prev_r;
    assign s_shift = slave_active && !sck_st_r && sck_prev_r;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_cnt_r <= `FIRST_BIT;
            s_done_r <= 1'b0;
        end else if (!slave_active) begin
            s_cnt_r <= `FIRST_BIT;
            s_done_r <= 1'b0;
        end else begin
            s_done_r <= s_sample && s_cnt_r == `LAST_BIT;
            if (s_sample) begin
                s_cnt_r <= s_cnt_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shift register and output bit
    // ------------------------------------------------------------------
    assign sample = m_shift || m_done || s_sample;
    assign shifted = bit_order_select_r
        ? {shift_register_r[6:0], si_st_r}
        : {si_st_r, shift_register_r[7:1]};
    assign byte_done = m_done || s_done_r;
    assign tx_load = transmit_enable_bit_r && !tx_empty_r && !tx_wr
        && (start || (slave_active && s_cnt_r == `FIRST_BIT && !s_sample));

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_register_r <= `RST_BYTE;
        end else if (tx_load) begin
            shift_register_r <= tx_data_r;
        end else if (sample) begin
            shift_register_r <= shifted;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_bit_r <= 1'b0;
        end else if (tx_load) begin
            out_bit_r <= lead_bit(bit_order_select_r, tx_data_r);
        end else if (m_shift || s_shift) begin
            out_bit_r <= lead_bit(bit_order_select_r,
                m_shift ? shifted : shift_register_r);
        end
    end

    // ------------------------------------------------------------------
    // Receive path and status flags
    // ------------------------------------------------------------------
    assign rx_store = byte_done && receive_enable_bit_r
        && !overrun_error_flag_r;
    assign overrun_set = rx_store && receive_data_full_flag_r;
    assign tx_end_set = byte_done && transmit_enable_bit_r && tx_empty_r
        && !tx_load;
    assign clr_overrun = status_wr && !reg_wdata_i[`BIT_OVERRUN] && seen_r[2];
    assign clr_tx_end = status_wr && !reg_wdata_i[`BIT_TX_END] && seen_r[1];
    assign clr_conflict = status_wr && !reg_wdata_i[`BIT_CONFLICT]
        && seen_r[0];

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            receive_data_register_r <= `RST_BYTE;
        end else if (rx_store && !receive_data_full_flag_r) begin
            receive_data_register_r <= m_done ? shifted
                : shift_register_r;
        end
    end

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            receive_data_full_flag_r <= 1'b0;
        end else if (rx_store) begin
            receive_data_full_flag_r <= 1'b1;
        end else if (reg_rd_i && reg_addr_i == `ADDR_RX_DATA) begin
            receive_data_full_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            overrun_error_flag_r <= 1'b0;
            tx_end_r <= 1'b0;
            conflict_r <= 1'b0;
        end else begin
            if (overrun_set) begin
                overrun_error_flag_r <= 1'b1;
            end else if (clr_overrun) begin
                overrun_error_flag_r <= 1'b0;
            end
            if (tx_end_set) begin
                tx_end_r <= 1'b1;
            end else if (clr_tx_end || tx_wr) begin
                tx_end_r <= 1'b0;
            end
            if (conflict_set) begin
                conflict_r <= 1'b1;
            end else if (clr_conflict) begin
                conflict_r <= 1'b0;
            end
        end
    end

    // Flags read as 1 arm their clear; writing 1 does nothing
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_r <= 3'h0;
        end else if (status_rd) begin
            seen_r <= {overrun_error_flag_r, tx_end_r, conflict_r};
        end else if (status_wr) begin
            seen_r <= seen_r & ~{clr_overrun, clr_tx_end, clr_conflict};
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_empty_r <= 1'b1;
        end else if (tx_wr) begin
            tx_empty_r <= 1'b0;
        end else if (tx_load) begin
            tx_empty_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_status_r <= `RST_IRQ;
            irq_enable_r <= `RST_IRQ;
            irq_r <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == `ADDR_IRQ_ENABLE) begin
                irq_enable_r <= reg_wdata_i[`IRQ_W-1:0];
            end
            irq_status_r <= (irq_status_r
                & ~((reg_wr_i && reg_addr_i == `ADDR_IRQ_CLEAR)
                    ? reg_wdata_i[`IRQ_W-1:0] : `RST_IRQ))
                | {conflict_set, tx_end_set, overrun_set,
                   rx_store && !receive_data_full_flag_r};
            irq_r <= |(irq_status_r & irq_enable_r);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        status_val = 8'h00;
        status_val[`BIT_OVERRUN] = overrun_error_flag_r;
        status_val[`BIT_TX_END] = tx_end_r;
        status_val[`BIT_TX_EMPTY] = tx_empty_r;
        status_val[`BIT_RX_FULL] = receive_data_full_flag_r;
        status_val[`BIT_CONFLICT] = conflict_r;
        read_val = 8'h00;
        case (reg_addr_i)
            `ADDR_CONTROL_HIGH: begin
                read_val[`BIT_MASTER] = master_slave_select_r;
                read_val[`BIT_CLK_PIN] = clock_pin_select_r;
            end
            `ADDR_CONTROL_LOW: read_val[`BIT_PIN_MODE] = pin_mode_select_r;
            `ADDR_MODE_CONFIG: begin
                read_val[`BIT_ORDER] = bit_order_select_r;
                read_val[`RATE_MSB:`RATE_LSB] = clock_rate_r;
            end
            `ADDR_TX_RX_ENABLE: begin
                read_val[`BIT_TX_EN] = transmit_enable_bit_r;
                read_val[`BIT_RX_EN] = receive_enable_bit_r;
            end
            `ADDR_SERIAL_STATUS: read_val = status_val;
            `ADDR_RX_DATA: read_val = receive_data_register_r;
            `ADDR_TX_DATA: read_val = tx_data_r;
            `ADDR_IRQ_STATUS: read_val[`IRQ_W-1:0] = irq_status_r;
            `ADDR_IRQ_ENABLE: read_val[`IRQ_W-1:0] = irq_enable_r;
            `ADDR_STANDBY: read_val[`BIT_STANDBY] = module_standby_control_r;
            default: read_val = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd_i ? read_val : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o = rdata_r;
    assign irq_o = irq_r;
    assign serial_clock_pin_o = sck_r;
    assign serial_clock_pin_oe_o = master_active;
    assign serial_output_pin_o = out_bit_r;
    assign serial_output_pin_oe_o = transmit_enable_bit_r
        && (master_active || slave_active);

endmodule : sync_serial_unit
`default_nettype wire

// [verif/sync_serial_unit_properties.sv]
// Port checker of the serial unit
`timescale 1ns/10ps
`default_nettype none
module sync_serial_unit_properties (
    // Clock, reset and register port
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // Pins and interrupt
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe_o,
    input wire logic serial_output_pin_o,
    input wire logic serial_output_pin_oe_o,
    input wire logic irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic [7:0] d = reg_wdata_i;
    wire logic ck = serial_clock_pin_o;
    wire logic w0 = reg_wr_i && reg_addr_i == 16'hF0E0;
    logic [2:0] rate_r;
    // Rate is snooped from writes: the checker sees no registers
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) rate_r <= 3'h0;
        else if (reg_wr_i && reg_addr_i == 16'hF0E2) rate_r <= d[2:0];
    end
    slave_clk_off_a: assert property (w0 && !d[7] |=> !serial_clock_pin_oe_o)
        else $error("clock pin driven in slave mode");
    port_clk_off_a: assert property (w0 && !d[2] |=> !serial_clock_pin_oe_o)
        else $error("clock pin driven as a port");
    mode_idle_a: assert property (reg_wr_i && reg_addr_i == 16'hF0E1 && d[6]
        |=> !serial_clock_pin_oe_o && !serial_output_pin_oe_o)
        else $error("pins driven with mode select 1");
    tx_inhibit_a: assert property (reg_wr_i && reg_addr_i == 16'hF0E3 && !d[7]
        |=> !serial_output_pin_oe_o) else $error("data out driven with tx off");
    standby_idle_a: assert property (reg_wr_i && reg_addr_i == 16'hFFFB && !d[4]
        |=> !serial_clock_pin_oe_o && !serial_output_pin_oe_o)
        else $error("pins driven in standby");
    half_period_a: assert property (rate_r == 3'h5 && serial_clock_pin_oe_o
        && $rose(ck) |-> ck[*4] ##1 !ck) else $error("high phase not 4 cycles");
    bit_hold_a: assert property (serial_clock_pin_oe_o && ck && $past(ck)
        |-> $stable(serial_output_pin_o)) else $error("data moved while clock high");
    irq_mask_a: assert property (reg_wr_i && reg_addr_i == 16'hF0F1 && d == 8'h00
        |=> ##1 !irq_o) else $error("interrupt high with all masked");
    cover property ($rose(serial_clock_pin_oe_o));
    cover property ($rose(irq_o));
    cover property (w0 && !d[7]);
endmodule : sync_serial_unit_properties
bind sync_serial_unit sync_serial_unit_properties chk (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_o(serial_clock_pin_oe_o), .irq_o(irq_o),
    .serial_output_pin_o(serial_output_pin_o),
    .serial_output_pin_oe_o(serial_output_pin_oe_o));
`default_nettype wire

// [verif/serial_peer.sv]
// Far-side peer that swaps one byte per frame
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
    // Pins
    input wire logic sck_i,
    input wire logic sdo_i,
    output logic sdi_o,
    // Bench side
    input wire logic [7:0] tx_byte_i,
    output logic [7:0] rx_byte_o
);
    logic [2:0] idx_r = 3'h0;
    logic [2:0] rise_r = 3'h0;
    initial rx_byte_o = 8'h00;
    // Sample on the rising edge, LSB first
    always @(posedge sck_i) rx_byte_o <= {sdo_i, rx_byte_o[7:1]};
    // Index follows the rising count, so a start-up edge cannot skew it
    always @(posedge sck_i) rise_r <= rise_r + 3'h1;
    always @(negedge sck_i) idx_r <= rise_r;
    assign sdi_o = tx_byte_i[idx_r];
endmodule : serial_peer
`default_nettype wire

// [verif/tb_sync_serial_unit.sv]
// Bench of the serial unit over its register port
`timescale 1ns/10ps
`default_nettype none
module tb_sync_serial_unit;
    logic clk, rst_b, wr_s, rd_s, sck_w, sdo_w, sck_o, sck_oe, sdi, sdo, sdo_oe, irq;
    logic [15:0] addr;
    logic [7:0] wdat, rdata, pbyte, pgot;
    int failures = 0;
    int n_checks = 0;
    // Pull-down on the clock line, pull-up on the data line
    assign sck_w = sck_oe ? sck_o : 1'b0;
    assign sdo_w = sdo_oe ? sdo : 1'b1;
    sync_serial_unit dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
        .reg_wdata_i(wdat), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_o(sck_oe), .serial_input_pin_i(sdi),
        .serial_output_pin_o(sdo), .serial_output_pin_oe_o(sdo_oe), .irq_o(irq));
    serial_peer peer (.sck_i(sck_w), .sdo_i(sdo_w), .sdi_o(sdi),
        .tx_byte_i(pbyte), .rx_byte_o(pgot));
    always #5 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] e);
        n_checks++;
        if (seen !== e) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, e);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        addr <= a;
        wdat <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd
    // Fixed wait covers 16 half periods of 4 cycles plus pin sync
    task automatic xfer(input logic [7:0] t, input logic [7:0] p);
        pbyte <= p;
        wr(16'hF0EB, t);
        repeat (80) @(posedge clk);
    endtask : xfer
    task automatic results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        {clk, rst_b, wr_s, rd_s, addr, wdat, pbyte} = '0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(16'hF0E0, 8'h00);
        rd(16'hF0E4, 8'h04);
        rd(16'hF0E5, 8'h00);
        wr(16'hFFFB, 8'h10);
        wr(16'hF0E0, 8'h84);
        wr(16'hF0E2, 8'h05);
        wr(16'hF0E3, 8'hC0);
        $display("registers done");
        xfer(8'hA5, 8'h3C);
        #1 chk(8'(irq), 8'h00);
        rd(16'hF0E4, 8'h0E);
        rd(16'hF0F0, 8'h05);
        chk(pgot, 8'hA5);
        wr(16'hF0F1, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk(8'(irq), 8'h01);
        wr(16'hF0F2, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk(8'(irq), 8'h00);
        rd(16'hF0E9, 8'h3C);
        rd(16'hF0E4, 8'h0C);
        $display("byte done");
        xfer(8'h11, 8'h5A);
        xfer(8'h22, 8'hC3);
        rd(16'hF0E4, 8'h4E);
        wr(16'hF0E4, 8'h4F);
        rd(16'hF0E4, 8'h4E);
        xfer(8'h33, 8'h96);
        chk(pgot, 8'h22);
        rd(16'hF0E9, 8'h5A);
        wr(16'hF0E4, 8'h00);
        repeat (80) @(posedge clk);
        chk(pgot, 8'h33);
        rd(16'hF0E9, 8'h96);
        wr(16'hF0F1, 8'h0F);
        repeat (2) @(posedge clk);
        #1 chk(8'(irq), 8'h01);
        wr(16'hF0F1, 8'h00);
        wr(16'hF0E3, 8'h00);
        chk(8'(sdo_oe), 8'h00);
        wr(16'hF0E1, 8'h40);
        chk(8'(sck_oe), 8'h00);
        wr(16'hFFFB, 8'h00);
        wr(16'hF0E0, 8'h00);
        rd(16'hF0E4, 8'h0C);
        $display("overrun done");
        results();
    end
    initial begin
        #20000;
        failures++;
        results();
    end
endmodule : tb_sync_serial_unit
`default_nettype wire
